// ===== core/hic_pkg.sv
// Package of register offsets, field layouts and constants for the coalescing block
package hic_pkg;
   // Register byte offsets
   localparam logic [7:0]  PENDING_OFS    = 8'h08;
   localparam logic [7:0]  AVAIL_OFS      = 8'h0C;
   localparam logic [7:0]  VERSION_OFS    = 8'h10;
   localparam logic [7:0]  COAL_CTL_OFS   = 8'h14;
   localparam logic [7:0]  PORT_SEL_OFS   = 8'h18;
   localparam logic [7:0]  GLOBAL_CTL_OFS = 8'h04;
   // Control register field positions
   localparam int          TIMEOUT_LSB    = 16;
   localparam int          THRESH_LSB     = 8;
   localparam int          VSEL_LSB       = 3;
   localparam int          ENABLE_BIT     = 0;
   localparam int          GIE_BIT        = 1;
   // Values after reset
   localparam logic [15:0] TIMEOUT_RST    = 16'h0001;
   localparam logic [7:0]  THRESH_RST     = 8'h01;
   localparam logic [31:0] PORT_SEL_RST   = 32'h0000_0000;
   // Versions, major/minor
   localparam logic [15:0] MAJOR_0_95     = 16'h0000;
   localparam logic [15:0] MINOR_0_95     = 16'h0905;
   localparam logic [15:0] MAJOR_1_0      = 16'h0001;
   localparam logic [15:0] MINOR_1_0      = 16'h0000;
   localparam logic [15:0] MAJOR_1_1      = 16'h0001;
   localparam logic [15:0] MINOR_1_1      = 16'h0100;
   localparam logic [15:0] MAJOR_1_2      = 16'h0001;
   localparam logic [15:0] MINOR_1_2      = 16'h0200;
   // Millisecond tick from the 40 MHz clock
   localparam int          CLK_HZ         = 40_000_000;
   localparam int          TICK_MS        = 1;
   localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

// ===== core/hic_ms_tick.sv
// Millisecond enable pulse divided down from the controller clock
`timescale 1ns/1ps
module hic_ms_tick
#(
   parameter int unsigned TICK_CYCLES = hic_pkg::TICK_CYCLES
)
(
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic restart_i,
   output logic      tick_o
);
   logic [31:0] count_r;
   wire         wrap = (count_r == TICK_CYCLES - 1);

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || restart_i)
      begin
         count_r <= 32'h0000_0000;
         tick_o  <= 1'b0;
      end
      else
      begin
         count_r <= wrap ? 32'h0000_0000 : count_r + 32'h0000_0001;
         tick_o  <= wrap;
      end
   end

   tick_period_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || restart_i)
      tick_o |=> !tick_o)
      else $error("tick pulse longer than one cycle");
endmodule

// ===== core/hic_coalesce.sv
// Global pending status and completion coalescing with an AXI4-Lite register slave
//
// What this block does
// - One pending bit per port in the 32-bit status vector, set on port interrupts.
// - Only implemented ports and the coalescing bit are defined; others reserved.
// - Read-only availability mask loaded at initialisation; one means usable port.
// - Availability mask has at least one bit set, no more than port count plus one.
// - Version reads major in 31:16, minor in 15:0; 1.2 reads 0001h/0200h.
// - Earlier releases return their own major and minor version values.
// - Timeout field in 31:16 counts millisecond units, accurate within five percent.
// - Timer loads from timeout, counts only with outstanding commands, fires at zero.
// - Timer reloads with the timeout on every coalescing interrupt.
// - Completion counter counts selected completions; fires when equal to threshold.
// - Completion counter clears on every coalescing interrupt.
// - A zero threshold disables count-based interrupts; only the timer fires.
// - Read-only vector select names the pending bit set on coalescing interrupts.
// - Vector select points to a port slot marked unavailable.
// - Enable bit zero stops coalescing interrupts; one allows them.
// - Rising enable applies newly written timeout and threshold values.
// - Only ports in the port-select mask count; changes apply within one tick.
// - Global interrupt enable, reset clear, gates irq_o only; coal_event_o pulses whatever its value.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module hic_coalesce
#(
   parameter logic [31:0] AVAIL_MASK = 32'h0000_000F,
   parameter logic [4:0]  VEC_SEL    = 5'h1F,
   parameter logic [1:0]  RELEASE    = 2'h3
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [31:0] port_irq_i,
   input  wire logic [31:0] port_done_i,
   input  wire logic [31:0] port_busy_i,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             irq_o,
   output logic             coal_event_o
);
   typedef enum logic [1:0] {COAL_OFF, COAL_RUN} hic_coal_state_t;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == hic_pkg::PENDING_OFS) || (a == hic_pkg::AVAIL_OFS) ||
             (a == hic_pkg::VERSION_OFS) || (a == hic_pkg::COAL_CTL_OFS) ||
             (a == hic_pkg::PORT_SEL_OFS) || (a == hic_pkg::GLOBAL_CTL_OFS);
   endfunction

   // Software-visible state
   logic [31:0]     pending_r;
   logic [15:0]     timeout_ms_r;
   logic [7:0]      completion_threshold_r;
   logic            coal_en_r;
   logic [31:0]     port_sel_r;
   logic [31:0]     port_sel_live_r;
   logic            gie_r;
   logic [31:0]     avail_r;
   // Coalescing engine
   hic_coal_state_t state_r;
   logic [15:0]     coalesce_timer_r;
   logic [15:0]     timeout_live_r;
   logic [7:0]      threshold_live_r;
   logic [7:0]      completion_counter_r;
   // Bus capture
   logic [7:0]      aw_addr_r;
   logic            aw_have_r;
   logic [31:0]     w_data_r;
   logic [3:0]      w_strb_r;
   logic            w_have_r;
   logic            tick;

   // Version select
   wire [15:0] major_sel = (RELEASE == 2'h0) ? hic_pkg::MAJOR_0_95 :
                           (RELEASE == 2'h1) ? hic_pkg::MAJOR_1_0  :
                           (RELEASE == 2'h2) ? hic_pkg::MAJOR_1_1  : hic_pkg::MAJOR_1_2;
   wire [15:0] minor_sel = (RELEASE == 2'h0) ? hic_pkg::MINOR_0_95 :
                           (RELEASE == 2'h1) ? hic_pkg::MINOR_1_0  :
                           (RELEASE == 2'h2) ? hic_pkg::MINOR_1_1  : hic_pkg::MINOR_1_2;
   wire [31:0] version_word = {major_sel, minor_sel};

   wire [31:0] defined_mask = avail_r | (32'h0000_0001 << VEC_SEL);

   // Write channel: both halves captured in either order
   wire        wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
   wire [31:0] ctl_rd  = {timeout_ms_r, completion_threshold_r, VEC_SEL, 2'b00, coal_en_r};
   wire [31:0] ctl_new = merge_bytes(ctl_rd, w_data_r, w_strb_r);
   wire        wr_ctl  = wr_go && (aw_addr_r == hic_pkg::COAL_CTL_OFS);
   wire        wr_pend = wr_go && (aw_addr_r == hic_pkg::PENDING_OFS);
   wire        wr_sel  = wr_go && (aw_addr_r == hic_pkg::PORT_SEL_OFS);
   wire        wr_gctl = wr_go && (aw_addr_r == hic_pkg::GLOBAL_CTL_OFS);
   wire [31:0] pend_clr = wr_pend ? (w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                                {8{w_strb_r[1]}}, {8{w_strb_r[0]}}}) : '0;

   // Coalescing conditions
   wire        running     = (state_r == COAL_RUN);
   wire        any_busy    = |(port_busy_i & port_sel_live_r);
   wire        done_sel    = |(port_done_i & port_sel_live_r);
   wire [7:0]  count_inc   = completion_counter_r + 8'h01;
   wire        count_fire  = running && done_sel && (threshold_live_r != 8'h00) &&
                             (count_inc == threshold_live_r);
   wire        timer_fire  = running && tick && any_busy && (coalesce_timer_r <= 16'h0001);
   wire        coal_fire   = count_fire || timer_fire;
   wire [31:0] coal_bit    = coal_fire ? (32'h0000_0001 << VEC_SEL) : '0;
   wire        en_rise     = wr_ctl && ctl_new[hic_pkg::ENABLE_BIT] && !coal_en_r;

   // tick restarts on enable
   // A free-running phase would make the first timeout anywhere from zero to one tick
   hic_ms_tick u_tick
   (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .restart_i (en_rise),
      .tick_o    (tick)
   );

   wire [31:0] pend_set = (port_irq_i & avail_r) | coal_bit;
   wire [31:0] pending_nxt = (pending_r & ~pend_clr) | pend_set;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         pending_r <= '0;
      else
         pending_r <= pending_nxt & defined_mask;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         avail_r <= '0;
      else
         avail_r <= AVAIL_MASK;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         timeout_ms_r           <= hic_pkg::TIMEOUT_RST;
         completion_threshold_r <= hic_pkg::THRESH_RST;
         coal_en_r              <= 1'b0;
      end
      else if (wr_ctl)
      begin
         timeout_ms_r           <= ctl_new[31:16];
         completion_threshold_r <= ctl_new[15:8];
         coal_en_r              <= ctl_new[hic_pkg::ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         port_sel_r <= hic_pkg::PORT_SEL_RST;
         gie_r      <= 1'b0;
      end
      else
      begin
         if (wr_sel)
            port_sel_r <= merge_bytes(port_sel_r, w_data_r, w_strb_r);
         if (wr_gctl && w_strb_r[0])
            gie_r <= w_data_r[hic_pkg::GIE_BIT];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         port_sel_live_r <= hic_pkg::PORT_SEL_RST;
      else if (tick || !running)
         port_sel_live_r <= port_sel_r;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         state_r          <= COAL_OFF;
         timeout_live_r   <= hic_pkg::TIMEOUT_RST;
         threshold_live_r <= hic_pkg::THRESH_RST;
      end
      else
      begin
         case (state_r)
            COAL_OFF:
            begin
               if (en_rise)
               begin
                  state_r          <= COAL_RUN;
                  timeout_live_r   <= ctl_new[31:16];
                  threshold_live_r <= ctl_new[15:8];
               end
            end
            COAL_RUN:
            begin
               if (wr_ctl && !ctl_new[hic_pkg::ENABLE_BIT])
                  state_r <= COAL_OFF;
            end
            default:
               state_r <= COAL_OFF;
         endcase
      end
   end

   // timer decrements on tick while busy
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         coalesce_timer_r <= hic_pkg::TIMEOUT_RST;
      else if (en_rise)
         coalesce_timer_r <= ctl_new[31:16];
      else if (coal_fire)
         coalesce_timer_r <= timeout_live_r;
      else if (running && tick && any_busy)
         coalesce_timer_r <= coalesce_timer_r - 16'h0001;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || en_rise)
         completion_counter_r <= 8'h00;
      else if (coal_fire)
         completion_counter_r <= 8'h00;
      else if (running && done_sel)
         completion_counter_r <= count_inc;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         irq_o        <= 1'b0;
         coal_event_o <= 1'b0;
      end
      else
      begin
         irq_o        <= gie_r && (|pending_r);
         coal_event_o <= coal_fire;
      end
   end

   // AXI4-Lite write side; one write in flight
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= '0;
         w_strb_r      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= hic_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_r) ? hic_pkg::RESP_OKAY : hic_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode
   wire [7:0]  rd_addr = {s_axi_araddr[7:2], 2'b00};
   wire [31:0] rd_word = (rd_addr == hic_pkg::PENDING_OFS)    ? pending_r    :
                         (rd_addr == hic_pkg::AVAIL_OFS)      ? avail_r      :
                         (rd_addr == hic_pkg::VERSION_OFS)    ? version_word :
                         (rd_addr == hic_pkg::COAL_CTL_OFS)   ? ctl_rd       :
                         (rd_addr == hic_pkg::PORT_SEL_OFS)   ? port_sel_r   :
                         (rd_addr == hic_pkg::GLOBAL_CTL_OFS) ? {30'h0, gie_r, 1'b0} : '0;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= hic_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= mapped(rd_addr) ? hic_pkg::RESP_OKAY : hic_pkg::RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   avail_count_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !$past(reset_i) |-> (avail_r != 32'h0))
      else $error("availability mask empty");
   vec_slot_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      avail_r != 32'h0 |-> !avail_r[VEC_SEL])
      else $error("coalescing slot is an available port");
   coal_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      coal_fire |=> pending_r[VEC_SEL])
      else $error("coalescing pending bit not set");
   coal_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !coal_en_r |=> !coal_event_o)
      else $error("coalescing fired while disabled");
   count_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      coal_fire |=> completion_counter_r == 8'h00)
      else $error("completion counter not cleared");
   timer_reload_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      coal_fire && !en_rise |=> coalesce_timer_r == $past(timeout_live_r))
      else $error("timer not reloaded");
   thresh_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      threshold_live_r == 8'h00 && !timer_fire |-> !coal_fire)
      else $error("count fired with zero threshold");
   irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !gie_r |=> !irq_o)
      else $error("request while globally disabled");
   irq_any_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      gie_r && (|pending_r) |=> irq_o)
      else $error("request missing with pending bits");
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the coalescing block: register table, pending bits, coalescing
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
      logic        ck;
   } hic_row_t;

   logic        ref_clk_i;
   logic        reset_i;
   logic [31:0] port_irq_i;
   logic [31:0] port_done_i;
   logic [31:0] port_busy_i;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        irq_o;
   logic        coal_event_o;
   logic [31:0] ev_cnt = 32'h0;
   int          fails;
   int          n_compared;
   int          cyc = 0;
   int          wait_n;
   logic [31:0] rd_v;
   logic [1:0]  rs_v;

   // Reads of reset values first, then writes to read-only places, then read-write places
   hic_row_t rows [18] = '{
      '{1'b0, 8'h0C, 32'h0, 32'h0000_000F, 2'h0, 1'b1},
      '{1'b0, 8'h10, 32'h0, 32'h0001_0200, 2'h0, 1'b1},
      '{1'b0, 8'h14, 32'h0, 32'h0001_01F8, 2'h0, 1'b1},
      '{1'b0, 8'h18, 32'h0, 32'h0000_0000, 2'h0, 1'b1},
      '{1'b0, 8'h04, 32'h0, 32'h0000_0000, 2'h0, 1'b1},
      '{1'b0, 8'h08, 32'h0, 32'h0000_0000, 2'h0, 1'b1},
      '{1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 2'h0, 1'b0},
      '{1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0, 2'h0, 1'b0},
      '{1'b1, 8'h14, 32'h0001_0100, 32'h0, 2'h0, 1'b1},
      '{1'b0, 8'h0C, 32'h0, 32'h0000_000F, 2'h0, 1'b1},
      '{1'b0, 8'h10, 32'h0, 32'h0001_0200, 2'h0, 1'b1},
      '{1'b0, 8'h14, 32'h0, 32'h0001_01F8, 2'h0, 1'b1},
      '{1'b0, 8'h20, 32'h0, 32'h0, 2'h2, 1'b0},
      '{1'b1, 8'h00, 32'h0, 32'h0, 2'h2, 1'b1},
      '{1'b1, 8'h18, 32'h0000_0001, 32'h0, 2'h0, 1'b1},
      '{1'b0, 8'h18, 32'h0, 32'h0000_0001, 2'h0, 1'b1},
      '{1'b1, 8'h04, 32'h0000_0002, 32'h0, 2'h0, 1'b1},
      '{1'b0, 8'h04, 32'h0, 32'h0000_0002, 2'h0, 1'b1}
   };

   hic_coalesce hic_coalesce_i (
      .ref_clk_i    (ref_clk_i),    .reset_i       (reset_i),
      .port_irq_i   (port_irq_i),   .port_done_i   (port_done_i),
      .port_busy_i  (port_busy_i),  .s_axi_awvalid (awvalid),
      .s_axi_awready(awready),      .s_axi_awaddr  (awaddr),
      .s_axi_wvalid (wvalid),       .s_axi_wready  (wready),
      .s_axi_wdata  (wdata),        .s_axi_wstrb   (wstrb),
      .s_axi_bvalid (bvalid),       .s_axi_bready  (bready),
      .s_axi_bresp  (bresp),        .s_axi_arvalid (arvalid),
      .s_axi_arready(arready),      .s_axi_araddr  (araddr),
      .s_axi_rvalid (rvalid),       .s_axi_rready  (rready),
      .s_axi_rdata  (rdata),        .s_axi_rresp   (rresp),
      .irq_o        (irq_o),        .coal_event_o  (coal_event_o)
   );

   initial
   begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // Event pulses are counted per cycle, so a pulse that lingers shows up as extra events
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (coal_event_o === 1'b1)
         ev_cnt <= ev_cnt + 32'h1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_done;
      bit w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge ref_clk_i);
         if (!aw_done && awready === 1'b1)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge ref_clk_i); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge ref_clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge ref_clk_i); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, rs_v);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, rd_v, rs_v);
      chk(rd_v, e, "register read");
   endtask

   task automatic pulse(input logic [31:0] b, input int n);
      repeat (n)
      begin
         port_done_i <= b;
         @(posedge ref_clk_i);
         port_done_i <= 32'h0;
         @(posedge ref_clk_i);
      end
      repeat (3) @(posedge ref_clk_i);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      {reset_i, port_irq_i, port_done_i, port_busy_i} = {1'b1, 96'h0};
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      fails = 0;
      n_compared = 0;
      // Watchdog: the run needs about 41000 cycles, mostly the one millisecond timer case
      fork
         begin
            wait (cyc == 60000);
            fails = fails + 1;
            $display("mismatch at %0t: run did not finish in time", $time);
            tally_and_finish();
         end
      join_none
      repeat (8) @(posedge ref_clk_i);
      chk({26'h0, irq_o, coal_event_o, bvalid, rvalid, awready, arready}, 32'h0, "rst");
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      foreach (rows[i])
      begin
         if (rows[i].wr)
         begin
            axi_wr(rows[i].a, rows[i].d, rs_v);
            if (rows[i].ck) chk({30'h0, rs_v}, {30'h0, rows[i].r}, "write resp");
         end
         else
         begin
            axi_rd(rows[i].a, rd_v, rs_v);
            chk({30'h0, rs_v}, {30'h0, rows[i].r}, "read resp");
            if (rows[i].ck) chk(rd_v, rows[i].e, "row read");
         end
      end
      // Port 8 is unavailable, so only port 2 may latch
      port_irq_i <= 32'h0000_0104;
      @(posedge ref_clk_i);
      port_irq_i <= 32'h0;
      rdc(8'h08, 32'h0000_0004);
      chk({31'h0, irq_o}, 32'h1, "request with pending");
      wr(8'h08, 32'h0);
      rdc(8'h08, 32'h0000_0004);
      wr(8'h08, 32'h0000_0004);
      rdc(8'h08, 32'h0);
      chk({31'h0, irq_o}, 32'h0, "request after clear");
      wr(8'h04, 32'h0);
      port_irq_i <= 32'h0000_0001;
      @(posedge ref_clk_i);
      port_irq_i <= 32'h0;
      repeat (3) @(posedge ref_clk_i);
      chk({31'h0, irq_o}, 32'h0, "request masked");
      rdc(8'h08, 32'h0000_0001);
      wr(8'h08, 32'h0000_0001);
      wr(8'h04, 32'h0000_0002);
      // Timer only: zero threshold, one millisecond, selected port busy
      // nonzero timeout
      wr(8'h14, 32'h0001_0000);
      wr(8'h14, 32'h0001_0001);
      port_busy_i <= 32'h0000_0001;
      for (wait_n = 0; wait_n < 45000 && ev_cnt == 0; wait_n++) @(posedge ref_clk_i);
      port_busy_i <= 32'h0;
      chk(ev_cnt, 32'h1, "timer event");
      // One millisecond is 40000 cycles; five percent either way is allowed
      chk({31'h0, (wait_n > 38000 && wait_n < 42000)}, 32'h1, "timer period");
      rdc(8'h08, 32'h8000_0000);
      chk({31'h0, irq_o}, 32'h1, "coalescing request");
      wr(8'h08, 32'h8000_0000);
      pulse(32'h0000_0001, 3);
      chk(ev_cnt, 32'h1, "zero threshold");
      // Count of three; port 1 is not selected and must not count
      // disable before changing fields
      wr(8'h14, 32'h0001_0300);
      wr(8'h14, 32'h0001_0301);
      pulse(32'h0000_0001, 1);
      pulse(32'h0000_0002, 1);
      pulse(32'h0000_0001, 1);
      chk(ev_cnt, 32'h1, "below threshold");
      pulse(32'h0000_0001, 1);
      chk(ev_cnt, 32'h2, "at threshold");
      pulse(32'h0000_0001, 2);
      chk(ev_cnt, 32'h2, "counter cleared");
      pulse(32'h0000_0001, 1);
      chk(ev_cnt, 32'h3, "second batch");
      wr(8'h14, 32'h0001_0100);
      wr(8'h14, 32'h0001_0101);
      pulse(32'h0000_0001, 1);
      chk(ev_cnt, 32'h4, "new threshold");
      wr(8'h14, 32'h0001_0100);
      pulse(32'h0000_0001, 2);
      chk(ev_cnt, 32'h4, "disabled");
      // Reset in mid-run with a pending coalescing bit and the request up
      chk({31'h0, irq_o}, 32'h1, "request before reset");
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      chk({31'h0, irq_o}, 32'h0, "request after reset");
      rdc(8'h04, 32'h0);
      rdc(8'h08, 32'h0);
      rdc(8'h14, 32'h0001_01F8);
      tally_and_finish();
   end
endmodule
